// ==== dv/fbd_core_sva.sv ====
// Port checker for the four-bit core
`include "fbd_consts.vh"
module fbd_core_sva (
  input wire sys_clk,
  input wire resetn,
  input wire ce,
  input wire [10:0] prog_addr,
  input wire prog_rd,
  input wire [15:0] prog_data,
  input wire [3:0] wake_in,
  input wire core_sleep,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rel;
  // Core leaves reset two edges late, so checks wait for three
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rel <= 2'h0;
    else if (rel != 2'h3) rel <= rel + 2'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rel != 2'h3);
  sequence s_fetch;
    prog_rd;
  endsequence
  sequence s_exec(op);
    ce && prog_data[15:11] == op;
  endsequence
  // A skipped branch leaves pc where the fetch put it
  property p_branch(op);
    s_fetch ##1 s_exec(op) |=> prog_addr == {2'h0, $past(prog_data[8:0])}
      || prog_addr == $past(prog_addr);
  endproperty
  chk_jump_target: assert property (p_branch(`FBD_OP_JUMP))
    else $error("jump target wrong");
  chk_call_target: assert property (p_branch(`FBD_OP_CALL))
    else $error("call target wrong");
  chk_fetch_advance: assert property (s_fetch |=> prog_addr == $past(prog_addr) + 11'h1)
    else $error("fetch did not advance pc");
  chk_fetch_spacing: assert property (s_fetch |=> !prog_rd)
    else $error("fetches back to back");
  chk_sleep_quiet: assert property (core_sleep |-> !prog_rd)
    else $error("fetch while asleep");
  chk_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("request not acked");
  chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved without access");
  chk_ce_freeze: assert property (!ce |=> $stable(prog_addr) && $stable(core_sleep))
    else $error("state moved with ce low");
endmodule // fbd_core_sva

// ==== dv/fbd_prog_rom.sv ====
// Program memory model: synchronous, one cycle of latency
module fbd_prog_rom (
  input wire sys_clk,
  input wire [10:0] prog_addr,
  input wire prog_rd,
  output logic [15:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:2047];
  initial begin
    prog_data = 16'h0000;
    for (int i = 0; i < 2048; i++) mem[i] = 16'h3BF0;
  end
  // Outside its valid cycle the word is scrambled, not held
  always @(posedge sys_clk) begin
    prog_data <= prog_rd ? mem[prog_addr] : ~prog_data;
  end
endmodule // fbd_prog_rom

// ==== dv/tb_four_bit_mcu_instruction_decoder.sv ====
// Testbench for the four-bit core decoder
module tb_four_bit_mcu_instruction_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] a; logic [3:0] b; logic [15:0] ins; logic [6:0] ad;
    logic [3:0] ex; logic cy;} fbd_row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] wake_in = 4'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  wire [31:0] rdat;
  wire [10:0] prog_addr;
  wire [15:0] prog_data;
  wire prog_rd;
  wire core_sleep;
  wire ack;
  int err_total = 0;
  int n_compared = 0;
  fbd_row_t rows [25];
  fbd_core dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_data(prog_data), .wake_in(wake_in), .core_sleep(core_sleep),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  fbd_prog_rom rom (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic mem_rd(input logic [6:0] a);
    bus(1'b1, 8'h08, {25'h0, a}, 4'h1);
    bus(1'b0, 8'h0C, 32'h0, 4'h0);
  endtask
  task automatic restart();
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wait_sleep();
    int n;
    n = 0;
    while (core_sleep !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, core_sleep}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // Operand A sits at row 1 column 0, B in general register 3
    rows = '{
      '{4'h9, 4'h8, 16'h0103, 7'h03, 4'h1, 1'b1},
      '{4'h9, 4'h0, 16'h8107, 7'h10, 4'h0, 1'b1},
      '{4'h9, 4'h0, 16'h9108, 7'h10, 4'h1, 1'b1},
      '{4'h9, 4'h8, 16'h1103, 7'h03, 4'h1, 1'b1},
      '{4'h5, 4'h3, 16'h1903, 7'h03, 4'hE, 1'b1},
      '{4'h5, 4'h3, 16'h0903, 7'h03, 4'hE, 1'b1},
      '{4'h5, 4'h0, 16'h8902, 7'h10, 4'h3, 1'b0},
      '{4'h5, 4'h0, 16'h9905, 7'h10, 4'h0, 1'b0},
      '{4'h5, 4'hA, 16'h3103, 7'h03, 4'hF, 1'b0},
      '{4'h5, 4'h0, 16'hB108, 7'h10, 4'hD, 1'b0},
      '{4'hA, 4'hC, 16'h2103, 7'h03, 4'h8, 1'b0},
      '{4'h6, 4'h0, 16'hA103, 7'h10, 4'h2, 1'b0},
      '{4'h5, 4'hF, 16'h2903, 7'h03, 4'hA, 1'b0},
      '{4'h5, 4'h0, 16'hA90F, 7'h10, 4'hA, 1'b0},
      '{4'h7, 4'h0, 16'h4907, 7'h11, 4'h0, 1'b0},
      '{4'h7, 4'h0, 16'h5907, 7'h11, 4'h1, 1'b0},
      '{4'h7, 4'h0, 16'hC908, 7'h11, 4'h1, 1'b0},
      '{4'h7, 4'h0, 16'hD908, 7'h11, 4'h0, 1'b0},
      '{4'h6, 4'h0, 16'hF106, 7'h11, 4'h0, 1'b0},
      '{4'h6, 4'h0, 16'hF901, 7'h11, 4'h0, 1'b0},
      '{4'h9, 4'h0, 16'h4103, 7'h03, 4'h9, 1'b0},
      '{4'h0, 4'h4, 16'hC103, 7'h10, 4'h4, 1'b0},
      '{4'h0, 4'h0, 16'hE90C, 7'h10, 4'hC, 1'b0},
      '{4'h0, 4'h5, 16'h3873, 7'h03, 4'h2, 1'b1},
      '{4'h0, 4'h0, 16'h3CF0, 7'h11, 4'h1, 1'b0}
    };
    foreach (rows[k]) begin
      rom.mem[0] = 16'hE910;
      rom.mem[1] = 16'hE900 | rows[k].a;
      rom.mem[2] = 16'hE830 | rows[k].b;
      rom.mem[3] = rows[k].ins;
      rom.mem[4] = 16'hE911;
      rom.mem[5] = 16'h3BF0;
      restart();
      bus(1'b0, 8'h04, 32'h0, 4'h0);
      chk(q & 32'h0007_F000, 32'h0);
      wait_sleep();
      mem_rd(rows[k].ad);
      chk(q, {28'h0, rows[k].ex});
      bus(1'b0, 8'h04, 32'h0, 4'h0);
      chk(q & 32'h0007_47FF, {17'h0, rows[k].cy, 14'h6});
      $display("row %0d done", k);
    end
    // Two successive calls and returns, one skipping, then a halt release and a stop
    rom.mem[1] = 16'hE010;
    rom.mem[2] = 16'hE911;
    rom.mem[3] = 16'hE018;
    rom.mem[4] = 16'h3BF2;
    rom.mem[5] = 16'h3AF0;
    rom.mem[16] = 16'h6014;
    rom.mem[20] = 16'h39E0;
    rom.mem[24] = 16'h38E0;
    restart();
    wait_sleep();
    mem_rd(7'h11);
    chk(q, 32'h0);
    bus(1'b0, 8'h04, 32'h0, 4'h0);
    chk(q & 32'h0007_07FF, 32'h5);
    wake_in <= 4'h1;
    ce <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ce <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({31'h0, core_sleep}, 32'h1);
    wake_in <= 4'h2;
    repeat (6) @(posedge sys_clk);
    wait_sleep();
    bus(1'b0, 8'h04, 32'h0, 4'h0);
    chk(q & 32'h0000_07FF, 32'h6);
    bus(1'b1, 8'h0C, 32'hF, 4'h0);
    mem_rd(7'h11);
    chk(q, 32'h0);
    bus(1'b0, 8'h10, 32'h0, 4'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h00, 32'h0, 4'h0);
    chk(q, 32'h1);
    bus(1'b1, 8'h00, 32'h0, 4'h1);
    bus(1'b0, 8'h00, 32'h0, 4'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h00, 32'h1, 4'h1);
    bus(1'b0, 8'h00, 32'h0, 4'h0);
    chk(q, 32'h1);
    $display("call and sleep test done");
    conclude();
  end
  initial begin
    #1000000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule // tb_four_bit_mcu_instruction_decoder

bind fbd_core fbd_core_sva chk (.sys_clk, .resetn, .ce, .prog_addr, .prog_rd, .prog_data,
  .wake_in, .core_sleep, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o);

// ==== rtl/fbd_consts.vh ====
// Constants for the four-bit core instruction decoder
`ifndef FBD_CONSTS_VH
`define FBD_CONSTS_VH

// Opcode field, instruction bits 15..11
`define FBD_OP_ADD_R 5'h00
`define FBD_OP_SUB_R 5'h01
`define FBD_OP_SUM_WITH_CARRY_R 5'h02
`define FBD_OP_MINUS_WITH_BORROW_R 5'h03
`define FBD_OP_AND_R 5'h04
`define FBD_OP_XOR_R 5'h05
`define FBD_OP_OR_R 5'h06
`define FBD_OP_MISC 5'h07
`define FBD_OP_LOAD 5'h08
`define FBD_OP_SKEQ 5'h09
`define FBD_OP_SKIP_IF_UNEQUAL 5'h0B
`define FBD_OP_JUMP 5'h0C
`define FBD_OP_ADD_I 5'h10
`define FBD_OP_SUB_I 5'h11
`define FBD_OP_SUM_WITH_CARRY_I 5'h12
`define FBD_OP_MINUS_WITH_BORROW_I 5'h13
`define FBD_OP_AND_I 5'h14
`define FBD_OP_XOR_I 5'h15
`define FBD_OP_OR_I 5'h16
`define FBD_OP_STORE 5'h18
`define FBD_OP_SKIP_IF_NOT_BELOW 5'h19
`define FBD_OP_SKIP_IF_BELOW 5'h1B
`define FBD_OP_CALL 5'h1C
`define FBD_OP_MOVI 5'h1D
`define FBD_OP_SKBS 5'h1E
`define FBD_OP_SKBC 5'h1F

// Sub-codes of the misc group: middle field, third field and fourth field
`define FBD_MID_ROT 3'h0
`define FBD_MID_RET 3'h0
`define FBD_MID_RESUME_CALLER_AND_SKIP 3'h1
`define FBD_MID_STOP 3'h2
`define FBD_MID_HALT 3'h3
`define FBD_MID_IDLE 3'h4
`define FBD_F3_ROT 4'h7
`define FBD_F3_RET 4'hE
`define FBD_F3_SLEEP 4'hF
`define FBD_F4_ZERO 4'h0

// Status word bit positions
`define FBD_PSW_BCD 0
`define FBD_PSW_Z 1
`define FBD_PSW_CY 2
`define FBD_PSW_CMP 3

// Register byte offsets
`define FBD_REG_CTRL 8'h00
`define FBD_REG_STATUS 8'h04
`define FBD_REG_DM_ADDR 8'h08
`define FBD_REG_DM_DATA 8'h0C

// Reset values
`define FBD_RST_RUN 1'b1
`define FBD_RST_PC 11'h000
`define FBD_RST_SP 3'h0

`endif

// ==== rtl/fbd_core.v ====
// Four-bit core: fetch, decode and execute with a Wishbone register port
//
// Function
// (RULE1) Decode add, add-immediate, add-with-carry opcodes
// (RULE2) Decode subtract, subtract-immediate, subtract-with-borrow opcodes
// (RULE3) OR register or immediate with memory
// (RULE4) AND register or immediate with memory
// (RULE5) XOR register or immediate with memory
// (RULE6) Skip when memory equals immediate
// (RULE7) Skip when memory differs from immediate
// (RULE8) Skip when memory minus immediate no borrow
// (RULE9) Skip when memory minus immediate borrows
// (RULE10) Clear compare, skip if masked bits set
// (RULE11) Clear compare, skip if masked bits clear
// (RULE12) Load, store and immediate move opcodes
// (RULE13) Jump loads 11-bit address, top two zero
// (RULE14) Call decrements pointer, pushes pc, jumps
// (RULE15) Return pops pc, raises pointer, optional skip
// (RULE16) Stop instruction with release condition field
// (RULE17) Halt instruction with release condition field
// (RULE18) Immediate is unsigned 4-bit last field
// (RULE19) Bit tests use last field as mask
// (RULE20) Row high, column low form memory address
// (RULE21) Row and column select memory operand
// (RULE22) Reset clears every status word bit
// (RULE23) Rotate register right through carry
// (RULE24) Add and subtract set carry or borrow
// (RULE25) Idle op changes nothing, advances pc
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`include "fbd_consts.vh"

module fbd_core #(
  parameter GPR_ROW = 3'h0,
  parameter STACK_DEPTH = 8
) (
  input wire sys_clk,
  input wire resetn,
  input wire ce,
  output wire [10:0] prog_addr,
  output wire prog_rd,
  input wire [15:0] prog_data,
  input wire [3:0] wake_in,
  output wire core_sleep,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  localparam S_FETCH = 2'h0;
  localparam S_EXEC = 2'h1;
  localparam S_HALT = 2'h2;
  localparam S_STOP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_meta;
  reg rst_sync;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [1:0] state;
  reg [10:0] pc;
  reg [2:0] stack_ptr;
  reg [10:0] return_addr_stack [0:STACK_DEPTH-1];
  reg [3:0] dmem [0:127];
  reg carry_flag;
  reg zero_flag;
  reg compare_flag;
  reg skip_pend;
  reg [3:0] wake_cond;
  reg run;
  reg [6:0] dm_addr;

  wire [3:0] status_word;
  assign status_word = {compare_flag, carry_flag, zero_flag, 1'b0};

  assign prog_addr = pc;
  assign prog_rd = ce & run & (state == S_FETCH);
  assign core_sleep = (state == S_HALT) | (state == S_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [4:0] op;
  wire [2:0] row_field;
  wire [3:0] column_field;
  wire [3:0] last_field;
  wire [6:0] maddr;
  wire [6:0] raddr;
  wire [3:0] mval;
  wire [3:0] rval;
  assign op = prog_data[15:11];
  assign row_field = prog_data[10:8];
  assign column_field = prog_data[7:4];
  assign last_field = prog_data[3:0]; // RULE18
  assign maddr = {row_field, column_field}; // RULE20
  assign raddr = {GPR_ROW[2:0], last_field};
  assign mval = dmem[maddr]; // RULE21
  assign rval = dmem[raddr];

  // Register forms work on (r) and (m); immediate forms on (m) and n4
  wire [3:0] alu_a;
  wire [3:0] alu_b;
  wire [4:0] alu_cin;
  wire [4:0] alu_sum;
  wire [4:0] alu_dif;
  wire [4:0] cmp_dif;
  assign alu_a = op[4] ? mval : rval;
  assign alu_b = op[4] ? last_field : mval;
  assign alu_cin = {4'h0, op[1] & carry_flag};
  assign alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + alu_cin;
  assign alu_dif = {1'b0, alu_a} - {1'b0, alu_b} - alu_cin;
  assign cmp_dif = {1'b0, mval} - {1'b0, last_field};

  reg next_wr;
  reg [6:0] next_waddr;
  reg [3:0] next_wdata;
  reg next_cy;
  reg next_z;
  reg next_cmp;
  reg next_skip;
  reg [10:0] next_pc;
  reg [2:0] next_sp;
  reg next_push;
  reg [1:0] next_state;
  reg [4:0] res;

  always @* begin
    next_wr = 1'b0;
    next_waddr = op[4] ? maddr : raddr;
    next_wdata = 4'h0;
    next_cy = carry_flag;
    next_z = zero_flag;
    next_cmp = compare_flag;
    next_skip = 1'b0;
    next_pc = pc;
    next_sp = stack_ptr;
    next_push = 1'b0;
    next_state = S_FETCH;
    res = 5'h00;
    case (op)
      `FBD_OP_ADD_R, `FBD_OP_SUM_WITH_CARRY_R, `FBD_OP_ADD_I, `FBD_OP_SUM_WITH_CARRY_I: begin
        res = alu_sum; // RULE1
        next_wr = 1'b1;
        next_wdata = res[3:0];
        next_cy = res[4]; // RULE24
        next_z = (res[3:0] == 4'h0);
      end
      `FBD_OP_SUB_R, `FBD_OP_MINUS_WITH_BORROW_R, `FBD_OP_SUB_I, `FBD_OP_MINUS_WITH_BORROW_I: begin
        res = alu_dif; // RULE2
        next_wr = 1'b1;
        next_wdata = res[3:0];
        next_cy = res[4]; // RULE24
        next_z = (res[3:0] == 4'h0);
      end
      `FBD_OP_OR_R, `FBD_OP_OR_I: begin
        next_wr = 1'b1;
        next_wdata = alu_a | alu_b; // RULE3
      end
      `FBD_OP_AND_R, `FBD_OP_AND_I: begin
        next_wr = 1'b1;
        next_wdata = alu_a & alu_b; // RULE4
      end
      `FBD_OP_XOR_R, `FBD_OP_XOR_I: begin
        next_wr = 1'b1;
        next_wdata = alu_a ^ alu_b; // RULE5
      end
      `FBD_OP_SKEQ: next_skip = (cmp_dif[3:0] == 4'h0); // RULE6
      `FBD_OP_SKIP_IF_UNEQUAL: next_skip = (cmp_dif[3:0] != 4'h0); // RULE7
      `FBD_OP_SKIP_IF_NOT_BELOW: next_skip = ~cmp_dif[4]; // RULE8
      `FBD_OP_SKIP_IF_BELOW: next_skip = cmp_dif[4]; // RULE9
      `FBD_OP_SKBS: begin
        next_cmp = 1'b0; // RULE10
        next_skip = ((mval & last_field) == last_field); // RULE19
      end
      `FBD_OP_SKBC: begin
        next_cmp = 1'b0; // RULE11
        next_skip = ((mval & last_field) == 4'h0); // RULE19
      end
      `FBD_OP_LOAD: begin
        next_wr = 1'b1; // RULE12
        next_waddr = raddr;
        next_wdata = mval;
      end
      `FBD_OP_STORE: begin
        next_wr = 1'b1; // RULE12
        next_waddr = maddr;
        next_wdata = rval;
      end
      `FBD_OP_MOVI: begin
        next_wr = 1'b1; // RULE12
        next_waddr = maddr;
        next_wdata = last_field;
      end
      `FBD_OP_JUMP: next_pc = {2'b00, prog_data[8:0]}; // RULE13
      `FBD_OP_CALL: begin
        next_sp = stack_ptr - 3'h1; // RULE14
        next_push = 1'b1;
        next_pc = {2'b00, prog_data[8:0]};
      end
      `FBD_OP_MISC: begin
        if (row_field == `FBD_MID_ROT && column_field == `FBD_F3_ROT) begin
          next_wr = 1'b1; // RULE23
          next_waddr = raddr;
          next_wdata = {carry_flag, rval[3:1]};
          next_cy = rval[0];
        end else if (column_field == `FBD_F3_RET && last_field == `FBD_F4_ZERO &&
                     (row_field == `FBD_MID_RET || row_field == `FBD_MID_RESUME_CALLER_AND_SKIP)) begin
          next_pc = return_addr_stack[stack_ptr]; // RULE15
          next_sp = stack_ptr + 3'h1;
          next_skip = (row_field == `FBD_MID_RESUME_CALLER_AND_SKIP);
        end else if (column_field == `FBD_F3_SLEEP && row_field == `FBD_MID_STOP) begin
          next_state = S_STOP; // RULE16
        end else if (column_field == `FBD_F3_SLEEP && row_field == `FBD_MID_HALT) begin
          next_state = S_HALT; // RULE17
        end
        // Idle op and unlisted codes fall through with no effect
      end
      default: next_state = S_FETCH; // RULE25
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire bus_hit;
  wire bus_wr;
  assign bus_hit = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_hit & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire exec_now;
  assign exec_now = (state == S_EXEC) & ~skip_pend;

  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= S_FETCH;
      pc <= `FBD_RST_PC;
      stack_ptr <= `FBD_RST_SP;
      carry_flag <= 1'b0; // RULE22
      zero_flag <= 1'b0;
      compare_flag <= 1'b0;
      skip_pend <= 1'b0;
      wake_cond <= 4'h0;
    end else if (ce) begin
      case (state)
        S_FETCH: begin
          if (run) begin
            pc <= pc + 11'h001;
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (skip_pend) begin
            // Skipped slot still costs its fetch, keeps timing uniform
            skip_pend <= 1'b0;
            state <= S_FETCH;
          end else begin
            pc <= next_pc;
            stack_ptr <= next_sp;
            carry_flag <= next_cy;
            zero_flag <= next_z;
            compare_flag <= next_cmp;
            skip_pend <= next_skip;
            wake_cond <= last_field;
            state <= next_state;
          end
        end
        S_HALT, S_STOP: begin
          // Zero condition never releases; only reset leaves
          if ((wake_cond & wake_in) != 4'h0) begin
            state <= S_FETCH; // RULE16 RULE17
          end
        end
        default: state <= S_FETCH;
      endcase
    end
  end

  // Return address is pc already stepped past the call
  always @(posedge sys_clk) begin
    if (ce && exec_now && next_push) begin
      return_addr_stack[next_sp] <= pc; // RULE14
    end
  end

  // Core write takes priority over a bus write in the same cycle
  always @(posedge sys_clk) begin
    if (ce) begin
      if (exec_now && next_wr) begin
        dmem[next_waddr] <= next_wdata;
      end else if (bus_wr && wb_adr_i == `FBD_REG_DM_DATA) begin
        dmem[dm_addr] <= wb_dat_i[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      run <= `FBD_RST_RUN;
      dm_addr <= 7'h00;
    end else if (ce) begin
      wb_ack_o <= bus_hit & ~wb_ack_o;
      if (bus_hit && !wb_ack_o) begin
        case (wb_adr_i)
          `FBD_REG_CTRL: wb_dat_o <= {31'h00000000, run};
          `FBD_REG_STATUS: wb_dat_o <= {8'h00, 2'h0, state, 1'b0, stack_ptr,
                                        status_word, 1'b0, pc};
          `FBD_REG_DM_ADDR: wb_dat_o <= {25'h0000000, dm_addr};
          `FBD_REG_DM_DATA: wb_dat_o <= {28'h0000000, dmem[dm_addr]};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      if (bus_wr && wb_adr_i == `FBD_REG_CTRL) begin
        run <= wb_dat_i[0];
      end
      if (bus_wr && wb_adr_i == `FBD_REG_DM_ADDR) begin
        dm_addr <= wb_dat_i[6:0];
      end
    end
  end

endmodule // fbd_core
